// >>> design/vbb_board.v
// VME board controller: master, single-cycle slave and interrupter
`timescale 1ns/1ns
`default_nettype none
`include "vbb_map.vh"

module vbb_board
#(
   parameter NREG = 4,
   parameter [1:0] SLV_SPACE = `VBB_SP_A24,
   parameter [31:0] SLV_BASE = 32'h00100000
)
(
   input wire MCLK,
   input wire RST_B,
   input wire CMD_VALID,
   input wire [2:0] CMD_OP,
   input wire [1:0] CMD_SPACE,
   input wire [1:0] CMD_SIZE,
   input wire CMD_SUPER,
   input wire [31:0] CMD_ADDR,
   input wire [31:0] CMD_WDATA,
   input wire [7:0] CMD_COUNT,
   output reg CMD_READY,
   output reg BEAT_TAKE,
   output reg RSP_VALID,
   output reg RSP_LAST,
   output reg RSP_ERR,
   output reg [31:0] RSP_DATA,
   input wire IRQ_REQ,
   input wire [2:0] IRQ_LEVEL,
   input wire [7:0] IRQ_VECTOR,
   output reg IRQ_BUSY,
   input wire [31:0] A_IN,
   input wire [31:0] D_IN,
   input wire [5:0] AM_IN,
   input wire AS_IN_B,
   input wire [1:0] DS_IN_B,
   input wire WRITE_IN_B,
   input wire IACK_IN_B,
   input wire DTACK_IN_B,
   input wire BERR_IN_B,
   input wire BG_IN_B,
   output reg [31:0] A_OUT,
   output reg A_OE,
   output reg [31:0] D_OUT,
   output reg D_OE,
   output reg [5:0] AM_OUT,
   output reg AM_OE,
   output reg AS_OE,
   output reg [1:0] DS_OE,
   output reg WRITE_OE,
   output reg LWORD_OE,
   output reg DTACK_OE,
   output reg BR_OE,
   output reg BBSY_OE,
   output reg [6:0] IRQ_OE
);

   // ========================================================
   // Constants and state codes
   localparam SW = 78;
   localparam [31:0] TMO_CYC = `VBB_TMO_NS / `VBB_CLK_NS;
   localparam [2:0] M_IDLE = 3'h0;
   localparam [2:0] M_REQ = 3'h1;
   localparam [2:0] M_ADDR = 3'h2;
   localparam [2:0] M_STRB = 3'h3;
   localparam [2:0] M_WACK = 3'h4;
   localparam [2:0] M_REL = 3'h5;
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_ACK = 2'h1;

   // ========================================================
   // Synchronised bus inputs
   wire [SW-1:0] sync_q;
   wire [31:0] a_s;
   wire [31:0] d_s;
   wire [5:0] am_s;
   wire as_s;
   wire [1:0] ds_s;
   wire write_s;
   wire iack_s;
   wire dtack_s;
   wire berr_s;
   wire bg_s;

   // Data and address share the strobes' delay, so they line up
   vbb_sync #(.W(SW), .RST_VAL({70'h0, 8'hFF})) u_sync
   (
      .CLK(MCLK),
      .RST_B(RST_B),
      .D({A_IN, D_IN, AM_IN, AS_IN_B, DS_IN_B, WRITE_IN_B, IACK_IN_B,
         DTACK_IN_B, BERR_IN_B, BG_IN_B}),
      .Q(sync_q)
   );
   assign {a_s, d_s, am_s} = sync_q[SW-1:8];
   assign {as_s, ds_s, write_s, iack_s} = sync_q[7:3];
   assign {dtack_s, berr_s, bg_s} = sync_q[2:0];

   // ========================================================
   // Master, slave and interrupter working state
   reg [2:0] m_state;
   reg [2:0] op;
   reg [1:0] sp;
   reg [1:0] sz;
   reg sup;
   reg [31:0] addr;
   reg [7:0] cnt;
   reg rmw_wr;
   reg err;
   reg [7:0] tmo;
   reg [1:0] s_state;
   reg [2:0] irq_lvl;
   reg [7:0] irq_vec;
   reg [31:0] regs [0:NREG-1];
   integer i;

   wire blk = (op == `VBB_OP_BLKRD) || (op == `VBB_OP_BLKWR);
   wire is_write = (op == `VBB_OP_WRITE) || (op == `VBB_OP_BLKWR) ||
      ((op == `VBB_OP_RMW) && rmw_wr);
   wire last = err || ((op == `VBB_OP_RMW) ? rmw_wr :
      (blk ? (cnt == 8'h01) : 1'b1));
   wire [3:0] bytes = (sz == `VBB_SZ_D8) ? 4'h1 :
      (sz == `VBB_SZ_D16) ? 4'h2 :
      (sz == `VBB_SZ_D32) ? 4'h4 : 4'h8;
   // Byte cycles pick one strobe by the odd/even address bit
   wire [1:0] ds_code = (sz == `VBB_SZ_D8) ?
      (addr[0] ? 2'h1 : 2'h2) : 2'h3;

   // ========================================================
   // Address modifier encode and slave decode
   function [5:0] am_code;
      input [1:0] s;
      input su;
      input bk;
      begin
         case (s)
            `VBB_SP_A16: am_code = su ? `VBB_AM_A16_SUP : `VBB_AM_A16_USR;
            `VBB_SP_A24: am_code = bk ?
               (su ? `VBB_AM_A24_SUP_BLK : `VBB_AM_A24_USR_BLK) :
               (su ? `VBB_AM_A24_SUP : `VBB_AM_A24_USR);
            default: am_code = bk ?
               (su ? `VBB_AM_A32_SUP_BLK : `VBB_AM_A32_USR_BLK) :
               (su ? `VBB_AM_A32_SUP : `VBB_AM_A32_USR);
         endcase
      end
   endfunction

   // Slave takes single data cycles only; code and block are refused
   wire am_a16 = (am_s == `VBB_AM_A16_SUP) || (am_s == `VBB_AM_A16_USR);
   wire am_a24 = (am_s == `VBB_AM_A24_SUP) || (am_s == `VBB_AM_A24_USR);
   wire am_a32 = (am_s == `VBB_AM_A32_SUP) || (am_s == `VBB_AM_A32_USR);
   wire am_ok = (SLV_SPACE == `VBB_SP_A16) ? am_a16 :
      (SLV_SPACE == `VBB_SP_A24) ? am_a24 : am_a32;
   wire [31:0] sp_mask = (SLV_SPACE == `VBB_SP_A16) ? `VBB_MASK_A16 :
      (SLV_SPACE == `VBB_SP_A24) ? `VBB_MASK_A24 : `VBB_MASK_A32;
   wire [31:0] win_mask = sp_mask & ~(NREG * 4 - 1);
   wire a_hit = ((a_s & win_mask) == (SLV_BASE & win_mask));
   wire [31:0] reg_idx = (a_s >> 2) % NREG;
   wire slv_sel = am_ok && a_hit && !as_s && iack_s &&
      (ds_s != 2'h3) && !AS_OE;
   wire iack_sel = IRQ_BUSY && !as_s && !iack_s && !ds_s[0] &&
      (a_s[3:1] == irq_lvl) && !AS_OE;

   // ========================================================
   // Master, slave and interrupter share the data bus drivers
   always @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         m_state <= M_IDLE;
         s_state <= S_IDLE;
         op <= 3'h0;
         sp <= 2'h0;
         sz <= 2'h0;
         sup <= 1'b0;
         addr <= 32'h0;
         cnt <= 8'h0;
         rmw_wr <= 1'b0;
         err <= 1'b0;
         tmo <= 8'h0;
         irq_lvl <= 3'h0;
         irq_vec <= 8'h0;
         CMD_READY <= 1'b0;
         BEAT_TAKE <= 1'b0;
         RSP_VALID <= 1'b0;
         RSP_LAST <= 1'b0;
         RSP_ERR <= 1'b0;
         RSP_DATA <= 32'h0;
         IRQ_BUSY <= 1'b0;
         A_OUT <= 32'h0;
         A_OE <= 1'b0;
         D_OUT <= 32'h0;
         D_OE <= 1'b0;
         AM_OUT <= 6'h0;
         AM_OE <= 1'b0;
         AS_OE <= 1'b0;
         DS_OE <= 2'h0;
         WRITE_OE <= 1'b0;
         LWORD_OE <= 1'b0;
         DTACK_OE <= 1'b0;
         BR_OE <= 1'b0;
         BBSY_OE <= 1'b0;
         IRQ_OE <= 7'h0;
         for (i = 0; i < NREG; i = i + 1)
            regs[i] <= 32'h0;
      end
      else
      begin
         BEAT_TAKE <= 1'b0;
         RSP_VALID <= 1'b0;
         case (m_state)
            M_IDLE:
            begin
               CMD_READY <= 1'b1;
               if (CMD_VALID && CMD_READY)
               begin
                  CMD_READY <= 1'b0;
                  op <= CMD_OP;
                  sp <= CMD_SPACE;
                  sz <= CMD_SIZE;
                  sup <= CMD_SUPER;
                  addr <= CMD_ADDR;
                  cnt <= (CMD_COUNT == 8'h0) ? 8'h01 : CMD_COUNT;
                  rmw_wr <= 1'b0;
                  err <= 1'b0;
                  BR_OE <= 1'b1;
                  m_state <= M_REQ;
               end
            end
            M_REQ:
            begin
               // Wait for the grant and a quiet bus before taking it
               if (!bg_s && as_s && (s_state == S_IDLE))
               begin
                  BR_OE <= 1'b0;
                  BBSY_OE <= 1'b1;
                  A_OUT <= addr & ((sp == `VBB_SP_A16) ? `VBB_MASK_A16 :
                     (sp == `VBB_SP_A24) ? `VBB_MASK_A24 : `VBB_MASK_A32);
                  A_OE <= 1'b1;
                  AM_OUT <= am_code(sp, sup, blk);
                  AM_OE <= 1'b1;
                  WRITE_OE <= is_write;
                  LWORD_OE <= sz[1];
                  m_state <= M_ADDR;
               end
            end
            M_ADDR:
            begin
               AS_OE <= 1'b1;
               if (is_write)
               begin
                  D_OUT <= CMD_WDATA;
                  D_OE <= 1'b1;
                  BEAT_TAKE <= 1'b1;
               end
               m_state <= M_STRB;
            end
            M_STRB:
            begin
               DS_OE <= ds_code;
               tmo <= 8'h0;
               m_state <= M_WACK;
            end
            M_WACK:
            begin
               tmo <= tmo + 8'h01;
               if (!dtack_s || !berr_s || (tmo == TMO_CYC[7:0]))
               begin
                  DS_OE <= 2'h0;
                  D_OE <= 1'b0;
                  err <= dtack_s;
                  if (!is_write)
                     RSP_DATA <= d_s;
                  m_state <= M_REL;
               end
            end
            M_REL:
            begin
               // Slave must drop its acknowledge before the next beat
               if (dtack_s && berr_s)
               begin
                  RSP_VALID <= 1'b1;
                  RSP_LAST <= last;
                  RSP_ERR <= err;
                  if (last)
                  begin
                     AS_OE <= 1'b0;
                     BBSY_OE <= 1'b0;
                     A_OE <= 1'b0;
                     AM_OE <= 1'b0;
                     WRITE_OE <= 1'b0;
                     LWORD_OE <= 1'b0;
                     m_state <= M_IDLE;
                  end
                  else if (op == `VBB_OP_RMW)
                  begin
                     // Address strobe stays low into the write half
                     rmw_wr <= 1'b1;
                     WRITE_OE <= 1'b1;
                     m_state <= M_ADDR;
                  end
                  else
                  begin
                     addr <= addr + {28'h0, bytes};
                     cnt <= cnt - 8'h01;
                     m_state <= M_ADDR;
                  end
               end
            end
            default:
               m_state <= M_IDLE;
         endcase

         // Slave and interrupt acknowledge answers
         case (s_state)
            S_IDLE:
            begin
               if (iack_sel)
               begin
                  D_OUT <= {24'h0, irq_vec};
                  D_OE <= 1'b1;
                  DTACK_OE <= 1'b1;
                  s_state <= S_ACK;
               end
               else if (slv_sel)
               begin
                  if (!write_s)
                     regs[reg_idx] <= d_s;
                  else
                  begin
                     D_OUT <= regs[reg_idx];
                     D_OE <= 1'b1;
                  end
                  DTACK_OE <= 1'b1;
                  s_state <= S_ACK;
               end
            end
            S_ACK:
            begin
               if (ds_s == 2'h3)
               begin
                  DTACK_OE <= 1'b0;
                  D_OE <= 1'b0;
                  s_state <= S_IDLE;
               end
            end
            default:
               s_state <= S_IDLE;
         endcase

         // Interrupter releases on acknowledge; a new request wins
         if (IRQ_REQ && (IRQ_LEVEL != 3'h0))
         begin
            IRQ_BUSY <= 1'b1;
            irq_lvl <= IRQ_LEVEL;
            irq_vec <= IRQ_VECTOR;
            IRQ_OE <= 7'h01 << (IRQ_LEVEL - 3'h1);
         end
         else if ((s_state == S_IDLE) && iack_sel)
         begin
            IRQ_BUSY <= 1'b0;
            IRQ_OE <= 7'h0;
         end
      end
   end

endmodule // vbb_board

`default_nettype wire

// >>> design/vbb_sync.v
// Two-stage synchroniser for a group of asynchronous bus inputs
`timescale 1ns/1ns
`default_nettype none

module vbb_sync
#(
   parameter W = 8,
   parameter [W-1:0] RST_VAL = {W{1'b1}}
)
(
   input wire CLK,
   input wire RST_B,
   input wire [W-1:0] D,
   output wire [W-1:0] Q
);

   // ========================================================
   // One pair of flops per bit
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : bit_sync
         reg meta;
         reg stable;
         always @(posedge CLK)
         begin
            if (!RST_B)
            begin
               meta <= RST_VAL[g];
               stable <= RST_VAL[g];
            end
            else
            begin
               meta <= D[g];
               stable <= meta;
            end
         end
         assign Q[g] = stable;
      end
   endgenerate

endmodule // vbb_sync

`default_nettype wire

// >>> shared/vbb_map.vh
// Bus codes, size codes and timing figures for the VME board controller
`ifndef VBB_MAP_VH
`define VBB_MAP_VH

// ========================================================
// Local command operations
`define VBB_OP_READ 3'h0
`define VBB_OP_WRITE 3'h1
`define VBB_OP_RMW 3'h2
`define VBB_OP_BLKRD 3'h3
`define VBB_OP_BLKWR 3'h4

// ========================================================
// Address spaces and data unit sizes
`define VBB_SP_A16 2'h0
`define VBB_SP_A24 2'h1
`define VBB_SP_A32 2'h2
`define VBB_SZ_D8 2'h0
`define VBB_SZ_D16 2'h1
`define VBB_SZ_D32 2'h2
`define VBB_SZ_D64 2'h3

// ========================================================
// Address modifier codes, data accesses only
`define VBB_AM_A16_SUP 6'h2D
`define VBB_AM_A16_USR 6'h29
`define VBB_AM_A24_SUP 6'h3D
`define VBB_AM_A24_USR 6'h39
`define VBB_AM_A24_SUP_BLK 6'h3F
`define VBB_AM_A24_USR_BLK 6'h3B
`define VBB_AM_A32_SUP 6'h0D
`define VBB_AM_A32_USR 6'h09
`define VBB_AM_A32_SUP_BLK 6'h0F
`define VBB_AM_A32_USR_BLK 6'h0B

// ========================================================
// Address masks per space
`define VBB_MASK_A16 32'h0000FFFF
`define VBB_MASK_A24 32'h00FFFFFF
`define VBB_MASK_A32 32'hFFFFFFFF

// ========================================================
// Timing
`define VBB_CLK_NS 100
`define VBB_TMO_NS 16000

`endif

// >>> test/testbench.sv
// Self-checking bench for the VME board controller
`timescale 1ns/1ns
`default_nettype none
`include "vbb_map.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module testbench;
   logic MCLK = 0, RST_B = 0, CMD_VALID = 0, CMD_SUPER = 1, IRQ_REQ = 0;
   logic [2:0] CMD_OP = 3'h0, IRQ_LEVEL = 3'h0;
   logic [1:0] CMD_SPACE = 2'h1, CMD_SIZE = 2'h2;
   logic [31:0] CMD_ADDR = 32'h0, CMD_WDATA = 32'h0, rdata, rfirst;
   logic [7:0] CMD_COUNT = 8'h0, IRQ_VECTOR = 8'h0;
   logic rerr;
   int nbeat, bad_count = 0, checked = 0;
   wire CMD_READY, BEAT_TAKE, RSP_VALID, RSP_LAST, RSP_ERR, IRQ_BUSY;
   wire [31:0] RSP_DATA, A_IN, D_IN, A_OUT, D_OUT;
   wire [5:0] AM_IN, AM_OUT;
   wire AS_IN_B, WRITE_IN_B, IACK_IN_B, DTACK_IN_B, BERR_IN_B, BG_IN_B;
   wire [1:0] DS_IN_B, DS_OE;
   wire A_OE, D_OE, AM_OE, AS_OE, WRITE_OE, LWORD_OE, DTACK_OE, BR_OE;
   wire BBSY_OE;
   wire [6:0] IRQ_OE;
   vbb_board i_dut (.*);
   vbb_bridge i_bridge (.*);
   always #50 MCLK = ~MCLK;
   // ========================================================
   // Command driver: whole command, collects every beat
   task automatic cmd(input [2:0] op, input [31:0] a, input [31:0] d,
      input [7:0] n);
      int k;
      for (k = 0; k < 9 && CMD_READY !== 1'h1; k++)
         @(negedge MCLK);
      CMD_OP = op;
      CMD_ADDR = a;
      CMD_WDATA = d;
      CMD_COUNT = n;
      CMD_VALID = 1'h1;
      @(negedge MCLK);
      CMD_VALID = 1'h0;
      nbeat = 0;
      for (k = 0; k < 900 && !(RSP_VALID & RSP_LAST); k++)
      begin
         @(negedge MCLK);
         if (BEAT_TAKE === 1'h1)
            CMD_WDATA = CMD_WDATA + 32'h1;
         nbeat += RSP_VALID;
         if (RSP_VALID === 1'h1 && nbeat == 1)
            rfirst = RSP_DATA;
      end
      rdata = RSP_DATA;
      rerr = RSP_ERR;
      `CHK(k < 900, 1'h1)
   endtask
   task automatic t_modes;
      logic [5:0] am [0:5] = '{6'h29, 6'h2D, 6'h39, 6'h3D, 6'h09, 6'h0D};
      for (int i = 0; i < 6; i++)
      begin
         CMD_SPACE = 2'(i / 2);
         CMD_SUPER = 1'(i % 2);
         cmd(`VBB_OP_WRITE, 32'h10, 32'hA5000000 + i, 8'h0);
         `CHK(i_bridge.last_am, am[i])
         `CHK(i_bridge.mem[4], 32'hA5000000 + i)
      end
      CMD_SPACE = 2'h1;
      for (int i = 0; i < 4; i++)
      begin
         CMD_SIZE = 2'(i);
         cmd(`VBB_OP_WRITE, 32'h10 | (i == 0), 32'h0, 8'h0);
         `CHK(i_bridge.last_ds, i == 0 ? 2'h1 : 2'h3)
         `CHK(i_bridge.last_lw, i >= 2)
      end
      CMD_SIZE = 2'h2;
   endtask
   task automatic t_read;
      i_bridge.mem[5] = 32'h12345678;
      cmd(`VBB_OP_READ, 32'h14, 32'h0, 8'h0);
      `CHK(rdata, 32'h12345678)
      `CHK(nbeat, 1)
      `CHK(rerr, 1'h0)
      cmd(`VBB_OP_WRITE, 32'h14, 32'h9, 8'h0);
      `CHK(rdata, 32'h12345678)
      `CHK(i_bridge.mem[5], 32'h9)
   endtask
   task automatic t_rmw;
      i_bridge.mem[6] = 32'h55;
      cmd(`VBB_OP_RMW, 32'h18, 32'h77, 8'h0);
      `CHK(rfirst, 32'h55)
      `CHK(i_bridge.mem[6], 32'h77)
      `CHK(i_bridge.last_a, 32'h18)
   endtask
   task automatic t_block;
      i_bridge.slow = 1'h1;
      cmd(`VBB_OP_BLKWR, 32'h20, 32'hB0, 8'h3);
      i_bridge.slow = 1'h0;
      for (int i = 0; i < 3; i++)
         `CHK(i_bridge.mem[8 + i], 32'hB0 + i)
      `CHK(i_bridge.last_am, 6'h3F)
      `CHK(nbeat, 3)
      cmd(`VBB_OP_BLKRD, 32'h20, 32'h0, 8'h2);
      `CHK(rfirst, 32'hB0)
      `CHK(rdata, 32'hB1)
   endtask
   // Unanswered address must end in the error response
   task automatic t_miss;
      cmd(`VBB_OP_READ, 32'h100, 32'h0, 8'h0);
      `CHK(rerr, 1'h1)
   endtask
   task automatic t_slave;
      logic [31:0] q;
      logic ok;
      i_bridge.mcycle(32'h100004, 6'h3D, 1'h1, 2'h3, 1'h0, 32'hCAFE, q, ok);
      `CHK(ok, 1'h1)
      i_bridge.mcycle(32'h100004, 6'h39, 1'h0, 2'h3, 1'h0, 32'h0, q, ok);
      `CHK(q, 32'hCAFE)
      i_bridge.mcycle(32'h100010, 6'h3D, 1'h0, 2'h3, 1'h0, 32'h0, q, ok);
      `CHK(ok, 1'h0)
      i_bridge.mcycle(32'h100004, 6'h3F, 1'h0, 2'h3, 1'h0, 32'h0, q, ok);
      `CHK(ok, 1'h0)
   endtask
   task automatic t_irq;
      logic [31:0] q;
      logic ok;
      @(negedge MCLK);
      IRQ_VECTOR = 8'h42;
      IRQ_REQ = 1'h1;
      @(negedge MCLK);
      `CHK(IRQ_BUSY, 1'h0)
      IRQ_LEVEL = 3'h5;
      @(negedge MCLK);
      IRQ_REQ = 1'h0;
      `CHK(IRQ_OE, 7'h10)
      `CHK(IRQ_BUSY, 1'h1)
      i_bridge.mcycle(32'hA, 6'h3D, 1'h0, 2'h1, 1'h1, 32'h0, q, ok);
      `CHK(q[7:0], 8'h42)
      `CHK(IRQ_BUSY, 1'h0)
   endtask
   task end_sim;
      $display("checked %0d, bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge MCLK);
      RST_B = 1'h1;
      t_modes;
      t_read;
      t_rmw;
      t_block;
      t_miss;
      t_slave;
      t_irq;
      end_sim;
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      #(100 * 8000);
      bad_count++;
      end_sim;
   end
endmodule // testbench
`default_nettype wire

// >>> test/vbb_board_sva.sv
// Assertion checker for the VME board controller ports
`timescale 1ns/1ns
`default_nettype none
module vbb_board_sva
#(
   parameter NREG = 4,
   parameter [31:0] SLV_BASE = 32'h00100000
)
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic CMD_VALID,
   input wire logic CMD_READY,
   input wire logic RSP_VALID,
   input wire logic RSP_LAST,
   input wire logic IRQ_REQ,
   input wire logic [2:0] IRQ_LEVEL,
   input wire logic IRQ_BUSY,
   input wire logic [6:0] IRQ_OE,
   input wire logic [31:0] A_IN,
   input wire logic [1:0] DS_IN_B,
   input wire logic IACK_IN_B,
   input wire logic [31:0] A_OUT,
   input wire logic A_OE,
   input wire logic D_OE,
   input wire logic [5:0] AM_OUT,
   input wire logic AM_OE,
   input wire logic AS_OE,
   input wire logic [1:0] DS_OE,
   input wire logic WRITE_OE,
   input wire logic DTACK_OE,
   input wire logic BR_OE,
   input wire logic BBSY_OE
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);
   // ========================================================
   // Steps of a command and of an interrupt
   sequence s_take;
      CMD_VALID && CMD_READY;
   endsequence
   sequence s_last;
      RSP_VALID && RSP_LAST;
   endsequence
   sequence s_irq;
      IRQ_REQ && IRQ_LEVEL != 3'h0;
   endsequence
   // A request in the same cycle would legally re-arm the level
   sequence s_ack;
      $rose(DTACK_OE) && !IACK_IN_B && !$past(IRQ_REQ);
   endsequence
   // ========================================================
   // Checks
   chk_take_busy:
      assert property (s_take |=> !CMD_READY && BR_OE)
      else $error("take did not raise bus request");
   chk_done_ready:
      assert property (s_last |=> CMD_READY)
      else $error("not idle after last beat");
   chk_beat_busy:
      assert property (RSP_VALID && !RSP_LAST |=> !CMD_READY)
      else $error("idle before last beat");
   chk_as_owner:
      assert property (AS_OE |-> BBSY_OE && !BR_OE)
      else $error("strobe without ownership");
   chk_addr_first:
      assert property ($rose(AS_OE) |-> A_OE && AM_OE && $stable(A_OUT)
         && $stable(AM_OUT))
      else $error("address not set before strobe");
   chk_am_legal:
      assert property (AM_OE |-> AM_OUT inside {6'h2D, 6'h29, 6'h3D,
         6'h39, 6'h3F, 6'h3B, 6'h0D, 6'h09, 6'h0F, 6'h0B})
      else $error("illegal modifier");
   chk_ds_in_as:
      assert property (DS_OE != 2'h0 |-> AS_OE && A_OE)
      else $error("data strobe outside cycle");
   chk_wr_data:
      assert property (DS_OE != 2'h0 && WRITE_OE |-> D_OE)
      else $error("write strobe without data");
   chk_slave_win:
      assert property ($rose(DTACK_OE) |-> !IACK_IN_B
         || A_IN - SLV_BASE < NREG * 4)
      else $error("answer outside window");
   chk_dtack_drop:
      assert property ($rose(&DS_IN_B) && DTACK_OE |-> ##[1:4] !DTACK_OE)
      else $error("acknowledge held too long");
   chk_irq_raise:
      assert property (s_irq |=> IRQ_BUSY && IRQ_OE[$past(IRQ_LEVEL) - 3'h1])
      else $error("interrupt level not raised");
   chk_irq_clear:
      assert property (s_ack |-> (IRQ_OE & (7'h01 << (A_IN[3:1] - 3'h1)))
         == 7'h00)
      else $error("interrupt kept after acknowledge");
endmodule // vbb_board_sva

bind vbb_board vbb_board_sva #(.NREG(NREG), .SLV_BASE(SLV_BASE))
   i_chk (.*);
`default_nettype wire

// >>> test/vbb_bridge.sv
// Bridge-side model: arbiter, memory slave, master and interrupt handler
`timescale 1ns/1ns
`default_nettype none
module vbb_bridge (
   input wire logic MCLK,
   input wire logic [31:0] A_OUT,
   input wire logic A_OE,
   input wire logic [31:0] D_OUT,
   input wire logic D_OE,
   input wire logic [5:0] AM_OUT,
   input wire logic AM_OE,
   input wire logic AS_OE,
   input wire logic [1:0] DS_OE,
   input wire logic WRITE_OE,
   input wire logic LWORD_OE,
   input wire logic DTACK_OE,
   input wire logic BR_OE,
   output wire logic [31:0] A_IN,
   output wire logic [31:0] D_IN,
   output wire logic [5:0] AM_IN,
   output wire logic AS_IN_B,
   output wire logic [1:0] DS_IN_B,
   output wire logic WRITE_IN_B,
   output wire logic IACK_IN_B,
   output wire logic DTACK_IN_B,
   output wire logic BERR_IN_B,
   output wire logic BG_IN_B
);
   logic [31:0] mem [0:15];
   logic [31:0] m_a = 32'hFFFFFFFF, m_d = 32'h0, s_d = 32'h0, last_a = 32'h0;
   logic [5:0] m_am = 6'h3F, last_am = 6'h0;
   logic [1:0] m_ds = 2'h0, last_ds = 2'h0;
   logic m_as = 0, m_wr = 0, m_ik = 0, m_doe = 0, s_doe = 0, s_ack = 0;
   logic grant = 0, slow = 0, last_lw = 0;
   int gcnt = 0, dcnt = 0;
   // Block beats keep the first address; the slave steps its own offset
   logic [31:0] boff = 32'h0;
   wire logic [31:0] ba = A_OUT + boff;
   // ========================================================
   // Wired bus; terminated lines read high once released
   assign A_IN = A_OE ? A_OUT : m_a;
   assign D_IN = D_OE ? D_OUT : s_doe ? s_d : m_doe ? m_d : 32'hFFFFFFFF;
   assign AM_IN = AM_OE ? AM_OUT : m_am;
   assign AS_IN_B = ~(AS_OE | m_as);
   assign DS_IN_B = ~(DS_OE | m_ds);
   assign WRITE_IN_B = ~(WRITE_OE | m_wr);
   assign IACK_IN_B = ~m_ik;
   assign DTACK_IN_B = ~(DTACK_OE | s_ack);
   assign BERR_IN_B = 1'h1;
   assign BG_IN_B = ~grant;
   // ========================================================
   // Arbiter and memory slave; slow mode stretches both
   always @(posedge MCLK)
   begin
      gcnt <= BR_OE ? gcnt + 1 : 0;
      grant <= BR_OE && !m_as && gcnt >= (slow ? 6 : 1);
      dcnt <= (DS_OE != 2'h0) ? dcnt + 1 : 0;
      if (!AS_OE)
         boff <= 32'h0;
      if (DS_OE == 2'h0)
      begin
         s_ack <= 0;
         s_doe <= 0;
      end
      else if (AS_OE && !s_ack && dcnt >= (slow ? 5 : 1)
         && ba < 32'h40)
      begin
         s_ack <= 1;
         last_a <= ba;
         last_am <= AM_OUT;
         last_ds <= DS_OE;
         last_lw <= LWORD_OE;
         // Block codes end in binary 11; only word beats are modelled
         if (AM_OUT[1:0] == 2'h3)
            boff <= boff + 32'h4;
         if (WRITE_OE)
            mem[ba[5:2]] <= D_OUT;
         else
         begin
            s_d <= mem[ba[5:2]];
            s_doe <= 1;
         end
      end
   end
   // ========================================================
   // One master or acknowledge cycle; ok low when unanswered
   task automatic mcycle(input [31:0] a, input [5:0] am, input wr,
      input [1:0] ds, input ik, input [31:0] d, output [31:0] q,
      output ok);
      int n;
      @(negedge MCLK);
      m_a = a;
      m_am = am;
      m_wr = wr;
      m_ik = ik;
      m_d = d;
      m_doe = wr;
      @(negedge MCLK);
      m_as = 1;
      m_ds = ds;
      for (n = 0; n < 40 && DTACK_OE !== 1'h1; n++)
         @(negedge MCLK);
      q = D_OUT;
      ok = n < 40;
      @(negedge MCLK);
      m_as = 0;
      m_ds = 2'h0;
      m_doe = 0;
      m_ik = 0;
      m_wr = 0;
      m_a = 32'hFFFFFFFF;
      m_am = 6'h3F;
      repeat (4) @(negedge MCLK);
   endtask
endmodule // vbb_bridge
`default_nettype wire
